// >>> tcspwm_channel.sv
// One modulator channel: holds its duty for a whole period and
// derives the sub-cycle waveform from it.
// Assumes the shared phase from tcspwm_counter.
`timescale 1ns/1ns
`default_nettype none
module tcspwm_channel
    import tcspwm_pkg::*;
#(
    parameter bit FOUR_WAY = 1'b1
)
(
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // Period phase
    tcspwm_phase_if.snk ph,
    // Duty from software
    input wire logic [7:0] duty,
    // Waveform
    output logic wave
);
    logic [7:0] duty_act_r;
    logic [7:0] duty_act_nxt;
    logic wave_r;
    logic wave_nxt;
    logic extra;

    always_comb begin
        // Swap only at the period edge so a period never mixes values
        duty_act_nxt = ph.period_end ? duty : duty_act_r;
        if (FOUR_WAY) begin
            // Coarse bits 7..2, extra count bits 1..0, 64-clock sub-cycles
            extra = (ph.count[7:6] < duty_act_r[1:0]);
            wave_nxt = ({1'b0, ph.count[5:0]} <
                        ({1'b0, duty_act_r[7:2]} + {6'h00, extra}));
        end else begin
            // Coarse bits 7..1, extra bit 0, 128-clock sub-cycles
            extra = (ph.count[7] < duty_act_r[0]);
            wave_nxt = ({1'b0, ph.count[6:0]} <
                        ({1'b0, duty_act_r[7:1]} + {7'h00, extra}));
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            duty_act_r <= DUTY_RST;
            wave_r <= 1'b0;
        end else begin
            duty_act_r <= duty_act_nxt;
            wave_r <= wave_nxt;
        end
    end

    assign wave = wave_r;
endmodule
`default_nettype wire

// >>> tcspwm_counter.sv
// Free-running 256-clock period counter shared by all channels.
// Assumes aclk is the system clock itself, with no prescaler.
`timescale 1ns/1ns
`default_nettype none
module tcspwm_counter
    import tcspwm_pkg::*;
(
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // Phase out
    tcspwm_phase_if.src ph
);
    logic [7:0] cnt_r;
    logic [7:0] cnt_nxt;

    always_comb begin
        cnt_nxt = cnt_r + 8'h01;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cnt_r <= 8'h00;
        end else begin
            cnt_r <= cnt_nxt;
        end
    end

    assign ph.count = cnt_r;
    assign ph.period_end = (cnt_r == TCSPWM_LAST_COUNT);
endmodule
`default_nettype wire

// >>> tcspwm_load.sv
// Averaging load on port A with pull-high resistors on every line.
// Assumes registered pin outputs of the modulator, one clock.
`timescale 1ns/1ns
`default_nettype none
module tcspwm_load
    import tcspwm_pkg::*;
(
    // Clock
    input wire logic aclk,
    // Design side
    input wire logic [7:0] port_a_out,
    input wire logic [7:0] port_a_oe_n,
    // Outside drive of the low lines
    input wire logic ext_en,
    input wire logic [3:0] ext_val,
    // Resolved lines and averages
    output logic [7:0] pin,
    output logic [8:0] avg [3]
);
    logic [8:0] acc [3] = '{default: 9'h0};
    logic [7:0] win = 8'h00;

    // Released lines float up unless ext_en drives lines 3..0 from ext_val; never keep the last level
    always_comb begin
        pin = port_a_out | port_a_oe_n;
        if (ext_en)
            pin[3:0] = (ext_val & port_a_oe_n[3:0]) | (pin[3:0] & ~port_a_oe_n[3:0]);
    end

    // Any 256-clock window of a steady wave holds duty high clocks
    always @(posedge aclk) begin
        win <= win + 8'h01;
        for (int c = 0; c < 3; c++) begin
            // Restart on the last sample so each window holds 256 samples
            acc[c] <= (win == 8'hff) ? 9'h0 : acc[c] + {8'h0, pin[4 + c]};
            if (win == 8'hff)
                avg[c] <= acc[c] + {8'h0, pin[4 + c]};
        end
    end
endmodule
`default_nettype wire

// >>> tcspwm_phase_if.sv
// Period phase shared from the period counter to the channels.
// Assumes one clock domain; the source drives, every channel listens.
`timescale 1ns/1ns
`default_nettype none
interface tcspwm_phase_if;
    logic [7:0] count;
    logic period_end;
    modport src (output count, output period_end);
    modport snk (input count, input period_end);
endinterface
`default_nettype wire

// >>> tcspwm_pkg.sv
// Shared constants of the three-channel sub-cycle pulse width modulator.
// Assumes a 32-bit AXI4-Lite register bus with byte addresses.
package tcspwm_pkg;

    // ------------------------------------------------------------------
    // Geometry
    // ------------------------------------------------------------------
    localparam int TCSPWM_CHANNELS = 3;
    localparam int TCSPWM_PERIOD_CLKS = 256;
    localparam int TCSPWM_FOUR_SUB_CLKS = 64;
    localparam int TCSPWM_TWO_SUB_CLKS = 128;
    localparam int TCSPWM_PIN_BASE = 4;
    localparam logic [7:0] TCSPWM_LAST_COUNT = 8'hff;

    // ------------------------------------------------------------------
    // Register map (byte addresses)
    // ------------------------------------------------------------------
    localparam int TCSPWM_ADDR_W = 8;
    localparam logic [7:0] OFS_DUTY_ZERO = 8'h00;
    localparam logic [7:0] OFS_DUTY_ONE = 8'h04;
    localparam logic [7:0] OFS_DUTY_TWO = 8'h08;
    localparam logic [7:0] OFS_PORT_DIR = 8'h0c;
    localparam logic [7:0] OFS_PORT_LATCH = 8'h10;
    localparam logic [7:0] OFS_PIN_STATUS = 8'h14;

    // Pin status fields
    localparam int STAT_PIN_LSB = 0;
    localparam int STAT_WAVE_LSB = 8;

    // Reset values
    localparam logic [7:0] DUTY_RST = 8'h00;
    localparam logic [7:0] PORT_DIR_RST = 8'hff;
    localparam logic [7:0] PORT_LATCH_RST = 8'h00;

    // Bus responses
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage

// >>> tcspwm_properties.sv
// Port checks of the modulator top: bus timing and pin reset state.
// Assumes binding to tcspwm_top, one aclk domain.
`timescale 1ns/1ns
`default_nettype none
module tcspwm_properties
    import tcspwm_pkg::*;
(
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // Register bus
    input wire logic awvalid,
    input wire logic awready,
    input wire logic wvalid,
    input wire logic wready,
    input wire logic bvalid,
    input wire logic bready,
    input wire logic [1:0] bresp,
    input wire logic arvalid,
    input wire logic arready,
    input wire logic [7:0] araddr,
    input wire logic rvalid,
    input wire logic rready,
    input wire logic [31:0] rdata,
    input wire logic [1:0] rresp,
    // Port A
    input wire logic [7:0] port_a_out,
    input wire logic [7:0] port_a_oe_n
);
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);

    sequence both_taken;
        awvalid && awready && wvalid && wready;
    endsequence
    sequence read_taken;
        arvalid && arready;
    endsequence

    a_write_answer: assert property (both_taken |-> ##2 bvalid)
        else $error("write response late");
    a_read_answer: assert property (read_taken |=> rvalid)
        else $error("read data late");
    a_bresp_hold: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
        else $error("write response dropped");
    a_rdata_hold: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
        else $error("read data dropped");
    a_write_gated: assert property (bvalid |-> !awready && !wready)
        else $error("write ready during response");
    a_read_gated: assert property (rvalid |-> !arready)
        else $error("read ready during data");
    a_unmapped_read: assert property (read_taken ##0 (araddr > 8'h14)
        |=> rresp == RESP_SLVERR && rdata == 32'h0)
        else $error("unmapped read not refused");
    a_upper_zero: assert property (rvalid |-> rdata[31:11] == 21'h0)
        else $error("unused read bits set");
    // Lines start as inputs so nothing fights the board
    a_reset_idle: assert property ($rose(aresetn) |-> port_a_oe_n == 8'hff && port_a_out == 8'h00)
        else $error("pins not idle after reset");
    a_dir_by_write: assert property (!$stable(port_a_oe_n)
        |-> bvalid || $past(bvalid) || $past(bvalid, 2))
        else $error("direction moved without a write");
endmodule
`default_nettype wire

// >>> tcspwm_test.sv
// Self-checking bench: four-way and two-way instances on one bus.
// Assumes the load model and the port checker alongside.
`timescale 1ns/1ns
`default_nettype none
`define CHK(nm, e, g) begin \
    samples_checked++; \
    if ((g) !== (e)) begin \
        miscompares++; \
        $display("wrong value %s exp %h got %h", nm, e, g); \
    end \
end
module tcspwm_test import tcspwm_pkg::*;;
    logic aclk = 0, aresetn = 0, awvalid = 0, wvalid = 0, bready = 0;
    logic arvalid = 0, rready = 0, ext_en = 1, cal_arm = 0, cal_done = 0;
    logic awready, wready, bvalid, arready, rvalid;
    logic [7:0] awaddr = 0, araddr = 0, pin, pin2, out2, oe2;
    logic [7:0] port_a_out, port_a_oe_n, dir_s = 8'hff, latch_s = 8'h00;
    logic [7:0] cyc = 0, phase = 0, kk = 0, cur_k = 0;
    logic [7:0] wr_duty [3] = '{default: 8'h0}, app [3] = '{default: 8'h0};
    logic [7:0] corner [8] = '{8'h00, 8'h01, 8'hff, 8'hfe, 8'hfd, 8'h40, 8'h03, 8'h80};
    logic [31:0] wdata = 0, rdata, seed = 32'hff3277f7, d;
    logic [1:0] bresp, rresp, r;
    logic [3:0] ext_val = 0, wstrb = 4'hf;
    logic [2:0] prot = 3'h0;
    logic [8:0] avg [3];
    int miscompares = 0, samples_checked = 0, blank = 0;

    always #5 aclk = ~aclk;

    // Static options differ per instance
    tcspwm_top #(.CFG_FOUR_WAY(1'b1), .CFG_PWM_SEL(3'h7)) dut_u (.aclk, .aresetn,
        .awvalid, .awready, .awaddr, .awprot(prot), .wvalid, .wready, .wdata,
        .wstrb, .bvalid, .bready, .bresp, .arvalid, .arready, .araddr,
        .arprot(prot), .rvalid, .rready, .rdata, .rresp, .port_a_in(pin),
        .port_a_out, .port_a_oe_n);
    tcspwm_top #(.CFG_FOUR_WAY(1'b0), .CFG_PWM_SEL(3'h5)) dut_b (.aclk, .aresetn,
        .awvalid, .awready(), .awaddr, .awprot(prot), .wvalid, .wready(),
        .wdata, .wstrb, .bvalid(), .bready, .bresp(), .arvalid, .arready(),
        .araddr, .arprot(prot), .rvalid(), .rready, .rdata(), .rresp(),
        .port_a_in(pin2), .port_a_out(out2), .port_a_oe_n(oe2));
    assign pin2 = out2 | oe2;
    tcspwm_load load_u (.aclk, .port_a_out, .port_a_oe_n, .ext_en, .ext_val,
        .pin, .avg);

    function automatic logic [31:0] lfsr(logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    function automatic logic wave(logic [7:0] v, logic four, logic [7:0] k);
        logic [7:0] hi;
        if (four)
            hi = {2'h0, v[7:2]} + 8'(k[7:6] < v[1:0]);
        else
            hi = {1'h0, v[7:1]} + 8'(k[7] < v[0]);
        return four ? k[5:0] < hi : k[6:0] < hi;
    endfunction

    function automatic logic exp_pin(int c, logic four, logic sel);
        if (dir_s[4 + c])
            return 1'b1;
        return latch_s[4 + c] & (sel ? wave(app[c], four, kk) : 1'b1);
    endfunction

    // Cycle monitor; period position taken from the first calibration pulse
    always @(posedge aclk) begin
        kk = cyc - phase;
        if (cal_arm && !cal_done && pin[4]) begin
            phase = cyc;
            kk = 8'h00;
            cal_done = 1'b1;
        end
        if (cal_done && kk == 8'h00)
            app = wr_duty;
        if (blank > 0)
            blank--;
        else if (cal_done)
            for (int c = 0; c < 3; c++) begin
                `CHK("four-way pin", exp_pin(c, 1'b1, 1'b1), pin[4 + c])
                `CHK("two-way pin", exp_pin(c, 1'b0, c != 1), pin2[4 + c])
            end
        cyc++;
        cur_k = kk;
    end

    task automatic wr(input logic [7:0] a, input logic [31:0] v, input logic [1:0] er);
        // Duty writes kept clear of the period edge
        if (a < 8'h0c && cal_done)
            while (cur_k < 8'd32 || cur_k > 8'd200)
                @(posedge aclk);
        blank = 6;
        awaddr <= a;
        wdata <= v;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        @(posedge aclk);
        // Only the watchdog ends a wait
        while (awvalid || wvalid) begin
            if (awready)
                awvalid <= 1'b0;
            if (wready)
                wvalid <= 1'b0;
            @(posedge aclk);
        end
        bready <= 1'b1;
        @(posedge aclk);
        while (!bvalid)
            @(posedge aclk);
        bready <= 1'b0;
        blank = 6;
        `CHK("bresp", er, bresp)
        if (er == RESP_OKAY && wstrb[0] && a < 8'h0c)
            wr_duty[a[3:2]] = v[7:0];
        if (er == RESP_OKAY && wstrb[0] && a == OFS_PORT_DIR)
            dir_s = v[7:0];
        if (er == RESP_OKAY && wstrb[0] && a == OFS_PORT_LATCH)
            latch_s = v[7:0];
    endtask

    task automatic rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] rs);
        araddr <= a;
        arvalid <= 1'b1;
        @(posedge aclk);
        while (arvalid) begin
            if (arready)
                arvalid <= 1'b0;
            @(posedge aclk);
        end
        rready <= 1'b1;
        @(posedge aclk);
        while (!rvalid)
            @(posedge aclk);
        rready <= 1'b0;
        v = rdata;
        rs = rresp;
    endtask

    task print_verdict;
        $display("checked %0d mismatches %0d", samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    initial begin
        repeat (30000) @(posedge aclk);
        miscompares++;
        print_verdict;
    end

    initial begin
        repeat (16) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        for (int i = 0; i < 5; i++) begin
            rd(8'(i * 4), d, r);
            `CHK("reset value", i == 3 ? {24'h0, PORT_DIR_RST} : 32'h0, d)
        end
        rd(8'h18, d, r);
        `CHK("unmapped resp", RESP_SLVERR, r)
        wr(8'h18, 32'h5a, RESP_SLVERR);
        wr(OFS_PIN_STATUS, 32'hff, RESP_OKAY);
        // Low byte strobe off: the latch must keep its value
        wstrb <= 4'he;
        wr(OFS_PORT_LATCH, 32'hff, RESP_OKAY);
        wstrb <= 4'hf;
        rd(OFS_PORT_LATCH, d, r);
        `CHK("masked write", {24'h0, PORT_LATCH_RST}, d)
        wr(OFS_DUTY_ZERO, 32'h1, RESP_OKAY);
        wr(OFS_PORT_DIR, 32'h8f, RESP_OKAY);
        wr(OFS_PORT_LATCH, 32'h70, RESP_OKAY);
        cal_arm = 1'b1;
        for (int t = 0; t < 800 && !cal_done; t++)
            @(posedge aclk);
        `CHK("calibration pulse", 1'b1, cal_done)
        for (int n = 0; n < 17; n++) begin
            seed = lfsr(seed);
            ext_val <= seed[19:16];
            ext_en <= seed[20];
            prot <= seed[2:0];
            for (int c = 0; c < 3; c++)
                wr(8'(c * 4), {24'h0, n < 8 ? corner[(n + c) % 8] : seed[8 * c +: 8]}, RESP_OKAY);
            if (n < 16) begin
                wr(OFS_PORT_LATCH, {24'h0, seed[31:24]}, RESP_OKAY);
                wr(OFS_PORT_DIR, {24'h0, 1'b1, seed[10:8] & seed[13:11], 4'hf}, RESP_OKAY);
            end else begin
                wr(OFS_PORT_LATCH, 32'h70, RESP_OKAY);
                wr(OFS_PORT_DIR, 32'h8f, RESP_OKAY);
            end
            rd(OFS_PIN_STATUS, d, r);
            `CHK("input lines", {1'b1, ext_en ? ext_val : 4'hf}, {d[7], d[3:0]})
            repeat (n < 16 ? 300 : 800) @(posedge aclk);
        end
        for (int c = 0; c < 3; c++)
            `CHK("average level", {1'b0, wr_duty[c]}, avg[c])
        print_verdict;
    end
endmodule

bind tcspwm_top tcspwm_properties chk_u (.aclk, .aresetn, .awvalid, .awready,
    .wvalid, .wready, .bvalid, .bready, .bresp, .arvalid, .arready, .araddr,
    .rvalid, .rready, .rdata, .rresp, .port_a_out, .port_a_oe_n);
`default_nettype wire

// >>> tcspwm_top.sv
// Three-channel sub-cycle pulse width modulator with its port A lines
// and an AXI4-Lite register slave.
// Assumes pin inputs synchronous to aclk; the outer wire resolves
// each pin from its output and active-low enable.
//
// How it works
// - Three channels, each with its own 8-bit software-written duty register.
// - The one shared period counter counts straight on the system clock, no prescaler.
// - A full modulation period is 256 system clocks.
// - Four-way mode splits the period into four 64-clock sub-cycles.
// - Four-way mode: bits 7..2 coarse value, bits 1..0 extra count.
// - Four-way: sub-cycle i high coarse+1 clocks if i below extra, else coarse.
// - Two-way mode splits the period into two 128-clock sub-cycles.
// - Two-way mode: bits 7..1 coarse value, bit 0 extra count.
// - Two-way: sub-cycle i high coarse+1 clocks if i below extra, else coarse.
// - Mode and modulator presence are static options, not registers.
// - Hardware derives all sub-cycles from the one duty value.
// - Channels 0, 1, 2 use port A lines 4, 5, 6 and their bits.
// - Waveform reaches a pin only if selected, direction 0, latch 1.
// - Latch bit 0 on a selected channel with direction 0 holds the pin low.
// - Selected channel with direction 1 leaves the pin an ordinary input.
`timescale 1ns/1ns
`default_nettype none
module tcspwm_top
    import tcspwm_pkg::*;
#(
    // Static options: subdivision mode and which channels drive pins
    parameter bit CFG_FOUR_WAY = 1'b1,
    parameter logic [2:0] CFG_PWM_SEL = 3'h7
)
(
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // AXI4-Lite write address
    input wire logic awvalid,
    output logic awready,
    input wire logic [7:0] awaddr,
    input wire logic [2:0] awprot,
    // AXI4-Lite write data
    input wire logic wvalid,
    output logic wready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    // AXI4-Lite write response
    output logic bvalid,
    input wire logic bready,
    output logic [1:0] bresp,
    // AXI4-Lite read address
    input wire logic arvalid,
    output logic arready,
    input wire logic [7:0] araddr,
    input wire logic [2:0] arprot,
    // AXI4-Lite read data
    output logic rvalid,
    input wire logic rready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    // Port A lines
    input wire logic [7:0] port_a_in,
    output logic [7:0] port_a_out,
    output logic [7:0] port_a_oe_n
);

    // ------------------------------------------------------------------
    // Modulator core
    // ------------------------------------------------------------------
    logic [7:0] duty_r [TCSPWM_CHANNELS];
    logic [7:0] duty_nxt [TCSPWM_CHANNELS];
    logic [TCSPWM_CHANNELS-1:0] wave;

    tcspwm_phase_if phase ();

    tcspwm_counter u_counter (
        .aclk(aclk),
        .aresetn(aresetn),
        .ph(phase)
    );

    // One channel per duty register
    for (genvar ch = 0; ch < TCSPWM_CHANNELS; ch++) begin : g_chan
        tcspwm_channel #(
            .FOUR_WAY(CFG_FOUR_WAY)
        ) u_chan (
            .aclk(aclk),
            .aresetn(aresetn),
            .ph(phase),
            .duty(duty_r[ch]),
            .wave(wave[ch])
        );
    end

    // ------------------------------------------------------------------
    // Write channel and register file
    // ------------------------------------------------------------------
    logic aw_have_r;
    logic aw_have_nxt;
    logic [7:0] aw_addr_r;
    logic [7:0] aw_addr_nxt;
    logic w_have_r;
    logic w_have_nxt;
    logic [31:0] w_data_r;
    logic [31:0] w_data_nxt;
    logic [3:0] w_strb_r;
    logic [3:0] w_strb_nxt;
    logic awready_r;
    logic awready_nxt;
    logic wready_r;
    logic wready_nxt;
    logic bvalid_r;
    logic bvalid_nxt;
    logic [1:0] bresp_r;
    logic [1:0] bresp_nxt;
    logic [7:0] dir_r;
    logic [7:0] dir_nxt;
    logic [7:0] latch_r;
    logic [7:0] latch_nxt;
    logic do_write;

    always_comb begin
        aw_have_nxt = aw_have_r;
        aw_addr_nxt = aw_addr_r;
        w_have_nxt = w_have_r;
        w_data_nxt = w_data_r;
        w_strb_nxt = w_strb_r;
        bvalid_nxt = bvalid_r;
        bresp_nxt = bresp_r;
        dir_nxt = dir_r;
        latch_nxt = latch_r;
        duty_nxt = duty_r;
        // Address and data are held separately, so either may come first
        if (awvalid && awready_r) begin
            aw_have_nxt = 1'b1;
            aw_addr_nxt = awaddr;
        end
        if (wvalid && wready_r) begin
            w_have_nxt = 1'b1;
            w_data_nxt = wdata;
            w_strb_nxt = wstrb;
        end
        do_write = aw_have_r && w_have_r && !bvalid_r;
        if (do_write) begin
            aw_have_nxt = 1'b0;
            w_have_nxt = 1'b0;
            bvalid_nxt = 1'b1;
            bresp_nxt = RESP_OKAY;
            unique case (aw_addr_r)
                OFS_DUTY_ZERO: begin
                    if (w_strb_r[0]) duty_nxt[0] = w_data_r[7:0];
                end
                OFS_DUTY_ONE: begin
                    if (w_strb_r[0]) duty_nxt[1] = w_data_r[7:0];
                end
                OFS_DUTY_TWO: begin
                    if (w_strb_r[0]) duty_nxt[2] = w_data_r[7:0];
                end
                OFS_PORT_DIR: begin
                    if (w_strb_r[0]) dir_nxt = w_data_r[7:0];
                end
                OFS_PORT_LATCH: begin
                    if (w_strb_r[0]) latch_nxt = w_data_r[7:0];
                end
                OFS_PIN_STATUS: begin
                    // Read-only; write is accepted and dropped
                end
                default: begin
                    bresp_nxt = RESP_SLVERR;
                end
            endcase
        end
        if (bvalid_r && bready) begin
            bvalid_nxt = 1'b0;
        end
        // No new beat is taken while one is held or a response waits
        awready_nxt = !aw_have_nxt && !bvalid_nxt;
        wready_nxt = !w_have_nxt && !bvalid_nxt;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_have_r <= 1'b0;
            aw_addr_r <= 8'h00;
            w_have_r <= 1'b0;
            w_data_r <= 32'h00000000;
            w_strb_r <= 4'h0;
            awready_r <= 1'b0;
            wready_r <= 1'b0;
            bvalid_r <= 1'b0;
            bresp_r <= RESP_OKAY;
            dir_r <= PORT_DIR_RST;
            latch_r <= PORT_LATCH_RST;
            for (int ch = 0; ch < TCSPWM_CHANNELS; ch++) begin
                duty_r[ch] <= DUTY_RST;
            end
        end else begin
            aw_have_r <= aw_have_nxt;
            aw_addr_r <= aw_addr_nxt;
            w_have_r <= w_have_nxt;
            w_data_r <= w_data_nxt;
            w_strb_r <= w_strb_nxt;
            awready_r <= awready_nxt;
            wready_r <= wready_nxt;
            bvalid_r <= bvalid_nxt;
            bresp_r <= bresp_nxt;
            dir_r <= dir_nxt;
            latch_r <= latch_nxt;
            duty_r <= duty_nxt;
        end
    end

    // ------------------------------------------------------------------
    // Read channel
    // ------------------------------------------------------------------
    logic arready_r;
    logic arready_nxt;
    logic rvalid_r;
    logic rvalid_nxt;
    logic [31:0] rdata_r;
    logic [31:0] rdata_nxt;
    logic [1:0] rresp_r;
    logic [1:0] rresp_nxt;
    logic [7:0] pin_level_r;
    logic [31:0] status_word;

    always_comb begin
        status_word = 32'h00000000;
        status_word[STAT_PIN_LSB +: 8] = pin_level_r;
        status_word[STAT_WAVE_LSB +: TCSPWM_CHANNELS] = wave;
        rvalid_nxt = rvalid_r;
        rdata_nxt = rdata_r;
        rresp_nxt = rresp_r;
        if (rvalid_r && rready) begin
            rvalid_nxt = 1'b0;
        end
        if (arvalid && arready_r) begin
            rvalid_nxt = 1'b1;
            rresp_nxt = RESP_OKAY;
            rdata_nxt = 32'h00000000;
            unique case (araddr)
                OFS_DUTY_ZERO: rdata_nxt[7:0] = duty_r[0];
                OFS_DUTY_ONE: rdata_nxt[7:0] = duty_r[1];
                OFS_DUTY_TWO: rdata_nxt[7:0] = duty_r[2];
                OFS_PORT_DIR: rdata_nxt[7:0] = dir_r;
                OFS_PORT_LATCH: rdata_nxt[7:0] = latch_r;
                OFS_PIN_STATUS: rdata_nxt = status_word;
                default: rresp_nxt = RESP_SLVERR;
            endcase
        end
        // One read in flight; the next address waits for the data beat
        arready_nxt = !rvalid_nxt;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            arready_r <= 1'b0;
            rvalid_r <= 1'b0;
            rdata_r <= 32'h00000000;
            rresp_r <= RESP_OKAY;
            pin_level_r <= 8'h00;
        end else begin
            arready_r <= arready_nxt;
            rvalid_r <= rvalid_nxt;
            rdata_r <= rdata_nxt;
            rresp_r <= rresp_nxt;
            pin_level_r <= port_a_in;
        end
    end

    // ------------------------------------------------------------------
    // Port A pin drivers
    // ------------------------------------------------------------------
    logic [7:0] pin_out_r;
    logic [7:0] pin_out_nxt;
    logic [7:0] pin_oe_n_r;
    logic [7:0] pin_oe_n_nxt;

    always_comb begin
        // Plain I/O: latch drives the line, direction 1 is an input
        pin_out_nxt = latch_r;
        pin_oe_n_nxt = dir_r;
        for (int ch = 0; ch < TCSPWM_CHANNELS; ch++) begin
            if (CFG_PWM_SEL[ch]) begin
                // Latch bit gates the waveform; a cleared bit forces low
                pin_out_nxt[TCSPWM_PIN_BASE + ch] =
                    latch_r[TCSPWM_PIN_BASE + ch] && wave[ch];
                // Direction 1 releases the pin as an ordinary input
                pin_oe_n_nxt[TCSPWM_PIN_BASE + ch] =
                    dir_r[TCSPWM_PIN_BASE + ch];
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pin_out_r <= 8'h00;
            pin_oe_n_r <= 8'hff;
        end else begin
            pin_out_r <= pin_out_nxt;
            pin_oe_n_r <= pin_oe_n_nxt;
        end
    end

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    assign awready = awready_r;
    assign wready = wready_r;
    assign bvalid = bvalid_r;
    assign bresp = bresp_r;
    assign arready = arready_r;
    assign rvalid = rvalid_r;
    assign rdata = rdata_r;
    assign rresp = rresp_r;
    assign port_a_out = pin_out_r;
    assign port_a_oe_n = pin_oe_n_r;

endmodule
`default_nettype wire
